/* hdl/dsm_data_space_map.sv */
// data-space decoder, read-only window and instruction pointer unit
`timescale 1ns/100ps
module dsm_data_space_map #(
	parameter int PORT_W = 8
) (
	input wire logic core_clk, // core clock, 125 MHz
	input wire logic rst, // async reset, high
	// core data-space access
	input wire logic [7:0] ds_addr, // data-space address
	input wire logic ds_wr, // write strobe, one cycle
	input wire logic ds_rd, // read strobe, one cycle
	input wire logic [7:0] ds_wdata, // write data
	output logic [7:0] ds_rdata, // read data, registered
	output logic ds_rvalid, // read data valid pulse
	// instruction pointer control from the core
	input wire logic ip_step, // advance to next byte
	input wire logic ip_jump, // load ip_target
	input wire logic ip_call, // push return, load ip_target
	input wire logic ip_return, // pop return address
	input wire logic [dsm_pkg::PM_AW-1:0] ip_target, // jump target
	input wire logic [dsm_pkg::PM_AW-1:0] ip_ret_addr, // address to push
	output logic [dsm_pkg::PM_AW-1:0] ip_addr, // fetch address
	// program memory data port, read combinationally at the registered address
	output logic [dsm_pkg::PM_AW-1:0] pm_addr, // window/external addr
	input wire logic [7:0] pm_rdata, // program byte
	// external program memory reader
	input wire logic readout_protect, // option bit, asynchronous
	input wire logic ext_rd, // external read request
	input wire logic [dsm_pkg::PM_AW-1:0] ext_addr, // external address
	output logic ext_ready, // request accepted this cycle
	output logic [7:0] ext_rdata, // external read data
	output logic ext_rvalid, // external data valid pulse
	output logic ext_denied, // refused by protection, pulse
	// converter and timer links
	input wire logic [7:0] conv_result, // converter result
	input wire logic conv_done, // converter status bit
	output logic [7:0] conv_ctl, // converter control bits
	output logic [7:0] int_opt, // interrupt option register
	output logic [7:0] tmr_psc, // timer prescaler
	output logic [7:0] tmr_cnt, // timer down-counter
	output logic [7:0] tmr_stc, // timer status/control
	output logic [7:0] wdg_cnt, // watchdog counter
	// ports
	input wire logic [PORT_W-1:0] pa_pin_in, // port a pads
	output logic [PORT_W-1:0] pa_pin_out, // port a out value
	output logic [PORT_W-1:0] pa_pin_oe, // port a drive enable
	output logic [PORT_W-1:0] pa_pullup, // port a pull-ups
	input wire logic [PORT_W-1:0] pb_pin_in, // port b pads
	output logic [PORT_W-1:0] pb_pin_out, // port b out value
	output logic [PORT_W-1:0] pb_pin_oe, // port b drive enable
	output logic [PORT_W-1:0] pb_pullup // port b pull-ups
);
	import dsm_pkg::*;

	typedef enum logic [2:0] {
		SRC_REG = 3'b001,
		SRC_WIN = 3'b010,
		SRC_EXT = 3'b100
	} dsm_src_type;

	// core registers
	logic [7:0] ptr1_q, ptr2_q, shd1_q, shd2_q, work_q;
	logic [7:0] ptr1_d, ptr2_d, shd1_d, shd2_d, work_d;
	// peripheral registers
	logic [7:0] int_opt_q, int_opt_d, conv_ctl_q, conv_ctl_d;
	logic [7:0] psc_q, psc_d, cnt_q, cnt_d, stc_q, stc_d;
	logic [7:0] wdg_q, wdg_d;
	logic [BLK_W-1:0] win_blk_q, win_blk_d;
	// read pipeline
	logic [7:0] hold_q, hold_d, rdata_q, rdata_d;
	logic [PM_AW-1:0] pm_addr_q, pm_addr_d;
	dsm_src_type src_q, src_d;
	logic busy_q, busy_d, rvalid_q, rvalid_d;
	logic evalid_q, evalid_d, denied_q, denied_d;
	logic [7:0] edata_q, edata_d;
	// protection sync and instruction pointer
	logic prot1_q, prot2_q;
	logic [PM_AW-1:0] ip_q, ip_d, stack_top;
	// port views
	logic [PORT_W-1:0] pa_rd, pb_rd, pa_dir, pb_dir, pa_opt, pb_opt;
	logic [7:0] reg_rd;
	logic in_window, ext_take;

	// writes; reserved and read-only addresses fall through untouched
	always_comb begin
		ptr1_d = ptr1_q;
		ptr2_d = ptr2_q;
		shd1_d = shd1_q;
		shd2_d = shd2_q;
		work_d = work_q;
		int_opt_d = int_opt_q;
		win_blk_d = win_blk_q;
		conv_ctl_d = conv_ctl_q;
		psc_d = psc_q;
		cnt_d = cnt_q;
		stc_d = stc_q;
		wdg_d = wdg_q;
		if (ds_wr) begin
			unique case (ds_addr)
				ADDR_PTR1: ptr1_d = ds_wdata;
				ADDR_PTR2: ptr2_d = ds_wdata;
				ADDR_SHD1: shd1_d = ds_wdata;
				ADDR_SHD2: shd2_d = ds_wdata;
				ADDR_INT_OPT: int_opt_d = ds_wdata;
				// reserved top bits are simply dropped
				ADDR_WIN_SEL:
					win_blk_d = ds_wdata[WSEL_BLK_MSB:WSEL_BLK_LSB];
				ADDR_CONV_CTL: conv_ctl_d = ds_wdata;
				ADDR_TMR_PSC: psc_d = ds_wdata;
				ADDR_TMR_CNT: cnt_d = ds_wdata;
				ADDR_TMR_STC: stc_d = ds_wdata;
				ADDR_WDG_CNT: wdg_d = ds_wdata;
				ADDR_WORK: work_d = ds_wdata;
				default: ;
			endcase
		end
	end

	// undefined-at-reset registers still get a known value
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ptr1_q <= RST_UNDEF;
			ptr2_q <= RST_UNDEF;
			shd1_q <= RST_UNDEF;
			shd2_q <= RST_UNDEF;
			work_q <= RST_UNDEF;
			int_opt_q <= RST_UNDEF;
			win_blk_q <= '0;
			conv_ctl_q <= RST_CONV_CTL;
			psc_q <= RST_TMR_PSC;
			cnt_q <= RST_TMR_CNT;
			stc_q <= RST_TMR_STC;
			wdg_q <= RST_UNDEF;
		end else begin
			ptr1_q <= ptr1_d;
			ptr2_q <= ptr2_d;
			shd1_q <= shd1_d;
			shd2_q <= shd2_d;
			work_q <= work_d;
			int_opt_q <= int_opt_d;
			win_blk_q <= win_blk_d;
			conv_ctl_q <= conv_ctl_d;
			psc_q <= psc_d;
			cnt_q <= cnt_d;
			stc_q <= stc_d;
			wdg_q <= wdg_d;
		end
	end

	// port a and b register groups
	dsm_io_port #(.W(PORT_W)) u_port_a (
		.core_clk(core_clk),
		.rst(rst),
		.wdata(ds_wdata[PORT_W-1:0]),
		.data_we(ds_wr && ds_addr == ADDR_PA_DATA),
		.dir_we(ds_wr && ds_addr == ADDR_PA_DIR),
		.opt_we(ds_wr && ds_addr == ADDR_PA_OPT),
		.pin_in(pa_pin_in),
		.pin_out(pa_pin_out),
		.pin_oe(pa_pin_oe),
		.pin_pullup(pa_pullup),
		.data_rd(pa_rd),
		.dir_q(pa_dir),
		.opt_q(pa_opt)
	);

	dsm_io_port #(.W(PORT_W)) u_port_b (
		.core_clk(core_clk),
		.rst(rst),
		.wdata(ds_wdata[PORT_W-1:0]),
		.data_we(ds_wr && ds_addr == ADDR_PB_DATA),
		.dir_we(ds_wr && ds_addr == ADDR_PB_DIR),
		.opt_we(ds_wr && ds_addr == ADDR_PB_OPT),
		.pin_in(pb_pin_in),
		.pin_out(pb_pin_out),
		.pin_oe(pb_pin_oe),
		.pin_pullup(pb_pullup),
		.data_rd(pb_rd),
		.dir_q(pb_dir),
		.opt_q(pb_opt)
	);

	// register read mux; write-only and reserved places read as idle
	always_comb begin
		reg_rd = RD_IDLE;
		unique case (ds_addr)
			ADDR_PTR1: reg_rd = ptr1_q;
			ADDR_PTR2: reg_rd = ptr2_q;
			ADDR_SHD1: reg_rd = shd1_q;
			ADDR_SHD2: reg_rd = shd2_q;
			ADDR_PA_DATA: reg_rd = 8'(pa_rd);
			ADDR_PB_DATA: reg_rd = 8'(pb_rd);
			ADDR_PA_DIR: reg_rd = 8'(pa_dir);
			ADDR_PB_DIR: reg_rd = 8'(pb_dir);
			ADDR_PA_OPT: reg_rd = 8'(pa_opt);
			ADDR_PB_OPT: reg_rd = 8'(pb_opt);
			ADDR_CONV_RES: reg_rd = conv_result;
			ADDR_CONV_CTL: begin
				// status bit is live; the rest echo the written bits
				reg_rd = conv_ctl_q;
				reg_rd[CONV_STAT_BIT] = conv_done;
			end
			ADDR_TMR_PSC: reg_rd = psc_q;
			ADDR_TMR_CNT: reg_rd = cnt_q;
			ADDR_TMR_STC: reg_rd = stc_q;
			ADDR_WDG_CNT: reg_rd = wdg_q;
			ADDR_WORK: reg_rd = work_q;
			default: reg_rd = RD_IDLE;
		endcase
	end

	assign in_window = ds_addr >= WIN_FIRST && ds_addr <= WIN_LAST;
	// core reads own the memory port; an external read waits for a gap
	assign ext_take = ext_rd && !ds_rd;
	assign ext_ready = !ds_rd;

	// read pipeline: request edge registers the address, answer edge takes the memory byte
	always_comb begin
		hold_d = hold_q;
		pm_addr_d = pm_addr_q;
		src_d = src_q;
		busy_d = 1'b0;
		rvalid_d = 1'b0;
		evalid_d = 1'b0;
		denied_d = 1'b0;
		rdata_d = rdata_q;
		edata_d = edata_q;
		if (ds_rd) begin
			busy_d = 1'b1;
			if (in_window) begin
				src_d = SRC_WIN;
				// block number on top, window offset below
				pm_addr_d = {win_blk_q, ds_addr[OFS_W-1:0]};
			end else begin
				src_d = SRC_REG;
				hold_d = reg_rd;
			end
		end else if (ext_take) begin
			if (prot2_q) begin
				denied_d = 1'b1;
			end else begin
				busy_d = 1'b1;
				src_d = SRC_EXT;
				pm_addr_d = ext_addr;
			end
		end
		if (busy_q) begin
			unique case (src_q)
				SRC_REG: begin
					rdata_d = hold_q;
					rvalid_d = 1'b1;
				end
				SRC_WIN: begin
					rdata_d = pm_rdata;
					rvalid_d = 1'b1;
				end
				SRC_EXT: begin
					edata_d = pm_rdata;
					evalid_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_q <= RD_IDLE;
			pm_addr_q <= '0;
			src_q <= SRC_REG;
			busy_q <= 1'b0;
			rvalid_q <= 1'b0;
			evalid_q <= 1'b0;
			denied_q <= 1'b0;
			rdata_q <= RD_IDLE;
			edata_q <= RD_IDLE;
		end else begin
			hold_q <= hold_d;
			pm_addr_q <= pm_addr_d;
			src_q <= src_d;
			busy_q <= busy_d;
			rvalid_q <= rvalid_d;
			evalid_q <= evalid_d;
			denied_q <= denied_d;
			rdata_q <= rdata_d;
			edata_q <= edata_d;
		end
	end

	// protection bit comes from the option array, so synchronise it;
	// it resets to protected so nothing leaks before it settles
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prot1_q <= 1'b1;
			prot2_q <= 1'b1;
		end else begin
			prot1_q <= readout_protect;
			prot2_q <= prot1_q;
		end
	end

	// instruction pointer: return beats call beats jump beats step
	always_comb begin
		ip_d = ip_q;
		if (ip_return) begin
			ip_d = stack_top;
		end else if (ip_call || ip_jump) begin
			ip_d = ip_target;
		end else if (ip_step) begin
			ip_d = ip_q + 12'h001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ip_q <= RST_IP;
		end else begin
			ip_q <= ip_d;
		end
	end

	dsm_return_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PM_AW)) u_stack (
		.core_clk(core_clk),
		.rst(rst),
		.push(ip_call && !ip_return),
		.pop(ip_return),
		.push_val(ip_ret_addr),
		.top_val(stack_top)
	);

	// outputs
	assign ds_rdata = rdata_q;
	assign ds_rvalid = rvalid_q;
	assign ext_rdata = edata_q;
	assign ext_rvalid = evalid_q;
	assign ext_denied = denied_q;
	assign pm_addr = pm_addr_q;
	assign ip_addr = ip_q;
	assign conv_ctl = conv_ctl_q;
	assign int_opt = int_opt_q;
	assign tmr_psc = psc_q;
	assign tmr_cnt = cnt_q;
	assign tmr_stc = stc_q;
	assign wdg_cnt = wdg_q;
endmodule

/* hdl/dsm_pkg.sv */
// constants for the data-space map and read-only window block
// Functional notes
// - instruction pointer is 12 bits, 4K space
// - six-entry 12-bit hardware return stack
// - data reads 40h-7Fh come from program memory
// - program memory split into 64-byte blocks
// - window offset forms low six address bits
// - window-select value gives upper program address
// - readout protection refuses external program reads
// - pointer and short direct registers at 80h-83h
// - port data, direction, option registers reset 00h
// - interrupt option and window-select are write-only
// - converter result read-only, control resets 40h
// - timer prescaler, down-counter, status at D2h-D4h
// - port read: outputs stored value, inputs pin
// - pins come up as inputs with pull-up
// - only low six window-select bits are used
package dsm_pkg;
	localparam int PM_AW = 12;
	localparam int BLK_W = 6;
	localparam int OFS_W = 6;
	localparam int STACK_DEPTH = 6;
	// data-space addresses
	localparam logic [7:0] WIN_FIRST = 8'h40;
	localparam logic [7:0] WIN_LAST = 8'h7f;
	localparam logic [7:0] ADDR_PTR1 = 8'h80;
	localparam logic [7:0] ADDR_PTR2 = 8'h81;
	localparam logic [7:0] ADDR_SHD1 = 8'h82;
	localparam logic [7:0] ADDR_SHD2 = 8'h83;
	localparam logic [7:0] ADDR_PA_DATA = 8'hc0;
	localparam logic [7:0] ADDR_PB_DATA = 8'hc1;
	localparam logic [7:0] ADDR_PA_DIR = 8'hc4;
	localparam logic [7:0] ADDR_PB_DIR = 8'hc5;
	localparam logic [7:0] ADDR_INT_OPT = 8'hc8;
	localparam logic [7:0] ADDR_WIN_SEL = 8'hc9;
	localparam logic [7:0] ADDR_PA_OPT = 8'hcc;
	localparam logic [7:0] ADDR_PB_OPT = 8'hcd;
	localparam logic [7:0] ADDR_CONV_RES = 8'hd0;
	localparam logic [7:0] ADDR_CONV_CTL = 8'hd1;
	localparam logic [7:0] ADDR_TMR_PSC = 8'hd2;
	localparam logic [7:0] ADDR_TMR_CNT = 8'hd3;
	localparam logic [7:0] ADDR_TMR_STC = 8'hd4;
	localparam logic [7:0] ADDR_WDG_CNT = 8'hd8;
	localparam logic [7:0] ADDR_WORK = 8'hff;
	// window-select field
	localparam int WSEL_BLK_LSB = 0;
	localparam int WSEL_BLK_MSB = 5;
	// converter control: bit 7 reads back as live status, all eight bits written
	localparam int CONV_STAT_BIT = 7;
	// reset values
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_CONV_CTL = 8'h40;
	localparam logic [7:0] RST_TMR_PSC = 8'h7f;
	localparam logic [7:0] RST_TMR_CNT = 8'hff;
	localparam logic [7:0] RST_TMR_STC = 8'h00;
	localparam logic [7:0] RST_UNDEF = 8'h00;
	localparam logic [PM_AW-1:0] RST_IP = 12'h000;
	localparam logic [7:0] RD_IDLE = 8'h00;
endpackage

/* hdl/dsm_return_stack.sv */
// six-deep return address stack built as a push-down shifter
`timescale 1ns/100ps
module dsm_return_stack #(
	parameter int DEPTH = dsm_pkg::STACK_DEPTH,
	parameter int WIDTH = dsm_pkg::PM_AW
) (
	input wire logic core_clk, // core clock
	input wire logic rst, // async reset, high
	input wire logic push, // store push_val on top
	input wire logic pop, // drop top entry
	input wire logic [WIDTH-1:0] push_val, // return address in
	output logic [WIDTH-1:0] top_val // current top entry
);
	import dsm_pkg::*;
	logic [WIDTH-1:0] stk_q [DEPTH];
	logic [WIDTH-1:0] stk_d [DEPTH];

	// a seventh push silently loses the oldest level, as the core does
	// end entries handled apart so no index leaves the array
	always_comb begin
		stk_d = stk_q;
		if (push) begin
			stk_d[0] = push_val;
			for (int i = 1; i < DEPTH; i++) begin
				stk_d[i] = stk_q[i-1];
			end
		end else if (pop) begin
			for (int i = 0; i < DEPTH-1; i++) begin
				stk_d[i] = stk_q[i+1];
			end
			stk_d[DEPTH-1] = '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				stk_q[i] <= '0;
			end
		end else begin
			stk_q <= stk_d;
		end
	end

	assign top_val = stk_q[0];
endmodule

/* hdl/dsm_io_port.sv */
// one i/o port: data, direction and option registers with pin sync
`timescale 1ns/100ps
module dsm_io_port #(
	parameter int W = 8
) (
	input wire logic core_clk, // core clock
	input wire logic rst, // async reset, high
	input wire logic [W-1:0] wdata, // write data
	input wire logic data_we, // write data register
	input wire logic dir_we, // write direction register
	input wire logic opt_we, // write option register
	input wire logic [W-1:0] pin_in, // pad levels, asynchronous
	output logic [W-1:0] pin_out, // pad output value
	output logic [W-1:0] pin_oe, // pad drive enable, high drives
	output logic [W-1:0] pin_pullup, // pull-up enable
	output logic [W-1:0] data_rd, // data register read view
	output logic [W-1:0] dir_q, // direction, 1 = output
	output logic [W-1:0] opt_q // option register
);
	import dsm_pkg::*;
	logic [W-1:0] dat_q, dat_d, dir_d, opt_d, sync1_q, sync2_q;

	// next register values
	always_comb begin
		dat_d = data_we ? wdata : dat_q;
		dir_d = dir_we ? wdata : dir_q;
		opt_d = opt_we ? wdata : opt_q;
	end

	// all cleared: every pin an input with pull-up out of reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dat_q <= RST_PORT;
			dir_q <= RST_PORT;
			opt_q <= RST_PORT;
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			dat_q <= dat_d;
			dir_q <= dir_d;
			opt_q <= opt_d;
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// inputs read the synchronised pad, outputs the stored bit
	assign data_rd = (dat_q & dir_q) | (sync2_q & ~dir_q);
	assign pin_out = dat_q;
	assign pin_oe = dir_q;
	// pull-up only on an input with option and data both clear
	assign pin_pullup = ~dir_q & ~opt_q & ~dat_q;
endmodule

/* verification/dsm_prog_mem.sv */
// program memory model: byte read at the registered address
`timescale 1ns/100ps
module dsm_prog_mem (
	input logic [dsm_pkg::PM_AW-1:0] addr, // registered read address
	output logic [7:0] data // program byte
);
	import dsm_pkg::*;
	// block number folded in so a wrong upper address shows in the data
	always_comb begin
		data = addr[7:0] ^ {addr[11:6], 2'b10};
	end
endmodule

/* verification/dsm_checker.sv */
// concurrent checks on the data-space map ports
`timescale 1ns/100ps
module dsm_checker #(
	parameter int PORT_W = 8
) (
	input logic core_clk, // core clock
	input logic rst, // async reset
	input logic [7:0] ds_addr, // data address
	input logic ds_wr, // write strobe
	input logic ds_rd, // read strobe
	input logic [7:0] ds_wdata, // write data
	input logic ds_rvalid, // read answer
	input logic ip_call, // call
	input logic ip_return, // return
	input logic [dsm_pkg::PM_AW-1:0] ip_target, // call target
	input logic [dsm_pkg::PM_AW-1:0] ip_ret_addr, // pushed address
	input logic [dsm_pkg::PM_AW-1:0] ip_addr, // fetch address
	input logic [dsm_pkg::PM_AW-1:0] pm_addr, // program address
	input logic readout_protect, // protection option
	input logic ext_rd, // external request
	input logic [dsm_pkg::PM_AW-1:0] ext_addr, // external address
	input logic ext_rvalid, // external answer
	input logic ext_denied, // external refusal
	input logic [7:0] conv_ctl, // converter control
	input logic [PORT_W-1:0] pa_pin_oe, // port a drive
	input logic [PORT_W-1:0] pa_pullup // port a pull-ups
);
	import dsm_pkg::*;
	logic [BLK_W-1:0] blk_q, blk_d;
	logic p1_q, p1_d, p2_q, p2_d;
	// set once software writes any port a register
	logic pa_cfg_q, pa_cfg_d;
	// shadow block and protection sync; the sync starts protected so
	// requests right after reset are expected to be refused
	always_comb begin
		blk_d = blk_q;
		if (ds_wr && ds_addr == ADDR_WIN_SEL)
			blk_d = ds_wdata[5:0];
		p1_d = readout_protect;
		p2_d = p1_q;
		pa_cfg_d = pa_cfg_q;
		if (ds_wr && (ds_addr == ADDR_PA_DATA ||
			ds_addr == ADDR_PA_DIR || ds_addr == ADDR_PA_OPT))
			pa_cfg_d = 1'b1;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			blk_q <= '0;
			p1_q <= 1'b1;
			p2_q <= 1'b1;
			pa_cfg_q <= 1'b0;
		end else begin
			blk_q <= blk_d;
			p1_q <= p1_d;
			p2_q <= p2_d;
			pa_cfg_q <= pa_cfg_d;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_call;
		ip_call && !ip_return;
	endsequence
	sequence s_ret;
		ip_return;
	endsequence
	sequence s_win_rd;
		ds_rd && ds_addr >= WIN_FIRST && ds_addr <= WIN_LAST;
	endsequence
	a_read_latency: assert property (ds_rd |-> ##2 ds_rvalid)
		else $error("read answer late");
	a_window_offset: assert property (s_win_rd |=>
		{2'b01, pm_addr[5:0]} == $past(ds_addr))
		else $error("window offset wrong");
	a_window_block: assert property (s_win_rd |=>
		pm_addr[11:6] == $past(blk_q))
		else $error("window block wrong");
	a_ext_refused: assert property (ext_rd && !ds_rd && p2_q |=>
		ext_denied ##1 !ext_rvalid)
		else $error("protected read not refused");
	a_ext_answer: assert property (ext_rd && !ds_rd && !p2_q |=>
		pm_addr == $past(ext_addr) ##1 ext_rvalid)
		else $error("external read not answered");
	a_call_target: assert property (s_call |=>
		ip_addr == $past(ip_target))
		else $error("call target not loaded");
	a_stack_return: assert property (s_call ##1 s_ret |=>
		ip_addr == $past(ip_ret_addr, 2))
		else $error("return address wrong");
	a_dir_write: assert property (ds_wr && ds_addr == ADDR_PA_DIR |=>
		pa_pin_oe == PORT_W'($past(ds_wdata)))
		else $error("direction write lost");
	a_pullup_inputs: assert property (!pa_cfg_q |->
		pa_pullup == {PORT_W{1'b1}} && pa_pin_oe == '0)
		else $error("pin not input with pull-up");
	a_conv_write: assert property (ds_wr && ds_addr == ADDR_CONV_CTL |=>
		conv_ctl == $past(ds_wdata))
		else $error("converter control write lost");
endmodule
bind dsm_data_space_map dsm_checker #(.PORT_W(PORT_W)) i_dsm_checker (
	.core_clk, .rst, .ds_addr, .ds_wr, .ds_rd, .ds_wdata, .ds_rvalid,
	.ip_call, .ip_return, .ip_target, .ip_ret_addr, .ip_addr, .pm_addr,
	.readout_protect, .ext_rd, .ext_addr, .ext_rvalid, .ext_denied,
	.conv_ctl, .pa_pin_oe, .pa_pullup);

/* verification/dsm_data_space_map_tb.sv */
// self-checking bench for the data-space map and read-only window
`timescale 1ns/100ps
module dsm_data_space_map_tb;
	import dsm_pkg::*;
	logic core_clk, ds_rvalid, ext_ready, ext_rvalid, ext_denied;
	logic rst = 1'b1, ds_wr = 1'b0, ds_rd = 1'b0, ip_step = 1'b0;
	logic ip_jump = 1'b0, ip_call = 1'b0, ip_return = 1'b0, ext_rd = 1'b0;
	logic readout_protect = 1'b0, conv_done = 1'b0;
	logic [7:0] ds_addr = 8'h00, ds_wdata = 8'h00, conv_result = 8'h00;
	logic [7:0] pa_pin_in = 8'h00, pb_pin_in = 8'h00;
	logic [7:0] ds_rdata, pm_rdata, ext_rdata, conv_ctl, int_opt, tmr_psc;
	logic [7:0] tmr_cnt, tmr_stc, wdg_cnt, pa_pin_out, pa_pin_oe, pa_pullup;
	logic [7:0] pb_pin_out, pb_pin_oe, pb_pullup;
	logic [11:0] ip_target = 12'h000, ip_ret_addr = 12'h000;
	logic [11:0] ext_addr = 12'h000, ip_addr, pm_addr;
	int fails = 0, checks = 0, cyc = 0;
	// address and expected-value tables
	logic [7:0] rst_a[10] = '{8'hc0, 8'hc1, 8'hc4, 8'hc5, 8'hcc, 8'hcd,
		8'hd1, 8'hd2, 8'hd3, 8'hd4};
	logic [7:0] rst_v[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h40, 8'h7f, 8'hff, 8'h00};
	logic [7:0] rw_a[9] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hd2, 8'hd3,
		8'hd4, 8'hd8, 8'hff};
	logic [7:0] rs_a[6] = '{8'hc2, 8'hc6, 8'hca, 8'hce, 8'hd5, 8'hd9};
	logic [7:0] ws[4] = '{8'h00, 8'h01, 8'hc3, 8'h3f};
	logic [7:0] wo[4] = '{8'h40, 8'h7f, 8'h45, 8'h7f};
	logic [11:0] wp[4] = '{12'h000, 12'h07f, 12'h0c5, 12'hfff};

	dsm_data_space_map i_dsm_data_space_map (.core_clk, .rst, .ds_addr,
		.ds_wr, .ds_rd, .ds_wdata, .ds_rdata, .ds_rvalid, .ip_step, .ip_jump,
		.ip_call, .ip_return, .ip_target, .ip_ret_addr, .ip_addr, .pm_addr,
		.pm_rdata, .readout_protect, .ext_rd, .ext_addr, .ext_ready,
		.ext_rdata, .ext_rvalid, .ext_denied, .conv_result, .conv_done,
		.conv_ctl, .int_opt, .tmr_psc, .tmr_cnt, .tmr_stc, .wdg_cnt,
		.pa_pin_in, .pa_pin_out, .pa_pin_oe, .pa_pullup, .pb_pin_in,
		.pb_pin_out, .pb_pin_oe, .pb_pullup);
	dsm_prog_mem i_dsm_prog_mem (.addr(pm_addr), .data(pm_rdata));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			results();
		end
	end
	// expected program byte, worked out independently of the design
	function automatic logic [7:0] pm_byte(input logic [11:0] a);
		return a[7:0] ^ {a[11:6], 2'b10};
	endfunction
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic done(input string s);
		$display("test %s done, %0d checks %0d fails", s, checks, fails);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		ds_addr <= a;
		ds_wdata <= d;
		ds_wr <= 1'b1;
		@(posedge core_clk);
		ds_wr <= 1'b0;
	endtask
	// answer stands for one cycle, after the edge that follows the take
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		ds_addr <= a;
		ds_rd <= 1'b1;
		#1;
		cmp(ext_ready, 1'b0);
		@(posedge core_clk);
		ds_rd <= 1'b0;
		@(posedge core_clk);
		#1;
		cmp(ds_rvalid, 1'b1);
		cmp(ds_rdata, exp);
	endtask
	task automatic xrd(input logic [11:0] a, input logic den);
		@(posedge core_clk);
		ext_addr <= a;
		ext_rd <= 1'b1;
		@(posedge core_clk);
		ext_rd <= 1'b0;
		#1;
		cmp(ext_denied, den);
		@(posedge core_clk);
		#1;
		cmp(ext_rvalid, !den);
		if (!den)
			cmp(ext_rdata, pm_byte(a));
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		cmp(pa_pullup, 8'hff);
		cmp(pb_pin_oe, 8'h00);
		foreach (rst_a[i]) rd(rst_a[i], rst_v[i]);
		done("reset values");
		foreach (rw_a[i]) wr(rw_a[i], rw_a[i] ^ 8'h5a);
		foreach (rw_a[i]) rd(rw_a[i], rw_a[i] ^ 8'h5a);
		cmp(tmr_psc, 8'h88);
		cmp(tmr_cnt, 8'h89);
		cmp(tmr_stc, 8'h8e);
		cmp(wdg_cnt, 8'h82);
		conv_done <= 1'b1;
		conv_result <= 8'h3c;
		wr(8'hd1, 8'h25);
		rd(8'hd1, 8'ha5);
		wr(8'hd0, 8'hc3);
		rd(8'hd0, 8'h3c);
		done("read write");
		wr(8'hc8, 8'h96);
		#1;
		cmp(int_opt, 8'h96);
		rd(8'hc8, 8'h00);
		rd(8'hc3, 8'h00);
		foreach (rs_a[i]) wr(rs_a[i], 8'hff);
		foreach (rs_a[i]) rd(rs_a[i], 8'h00);
		rd(8'h80, 8'hda);
		done("write only and reserved");
		foreach (ws[i]) begin
			wr(8'hc9, ws[i]);
			rd(wo[i], pm_byte(wp[i]));
		end
		rd(8'h3f, 8'h00);
		done("window");
		// only bonded pins are touched, and only by whole-byte writes
		wr(8'hc4, 8'h06);
		wr(8'hc0, 8'h0a);
		wr(8'hc5, 8'he0);
		wr(8'hc1, 8'h61);
		pa_pin_in <= 8'ha5;
		pb_pin_in <= 8'h0f;
		repeat (3) @(posedge core_clk);
		rd(8'hc0, 8'ha3);
		rd(8'hc1, 8'h6f);
		cmp(pa_pin_oe, 8'h06);
		cmp(pb_pin_out, 8'h61);
		cmp(pa_pin_out, 8'h0a);
		cmp(pb_pullup, 8'h1e);
		done("ports");
		xrd(12'h123, 1'b0);
		readout_protect <= 1'b1;
		repeat (3) @(posedge core_clk);
		xrd(12'h456, 1'b1);
		readout_protect <= 1'b0;
		repeat (3) @(posedge core_clk);
		xrd(12'hfff, 1'b0);
		done("external read");
		// six nested calls, then six returns in reverse order
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			ip_call <= 1'b1;
			ip_target <= 12'h800 + 12'(i);
			ip_ret_addr <= 12'h100 + 12'(i);
		end
		@(posedge core_clk);
		ip_call <= 1'b0;
		for (int i = 5; i >= 0; i--) begin
			ip_return <= 1'b1;
			@(posedge core_clk);
			#1;
			cmp(ip_addr, 12'h100 + 12'(i));
		end
		ip_return <= 1'b0;
		ip_jump <= 1'b1;
		ip_target <= 12'hfff;
		@(posedge core_clk);
		ip_jump <= 1'b0;
		ip_step <= 1'b1;
		@(posedge core_clk);
		ip_step <= 1'b0;
		#1;
		cmp(ip_addr, 12'h000);
		done("instruction pointer");
		results();
	end
endmodule
